// ---- shared/sji_pkg.sv ----
package sji_pkg;

    // ========================================
    // Instruction word layout
    localparam int INSN_W       = 14;
    localparam int DATA_W       = 8;
    localparam int FADDR_W      = 7;
    localparam int PC_W         = 13;
    localparam int LIT_W        = 11;
    localparam int LATCH_W      = 8;

    localparam int OP6_HI       = 13;
    localparam int OP6_LO       = 8;
    localparam int OP3_HI       = 13;
    localparam int OP3_LO       = 11;
    localparam int DEST_BIT     = 7;
    localparam int FADDR_HI     = 6;
    localparam int LIT_HI       = 10;
    localparam int LATCH_HI     = 4;
    localparam int LATCH_LO     = 3;

    localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
    localparam logic [5:0] OP_INC      = 6'h0A;
    localparam logic [2:0] OP_JUMP     = 3'h5;

    localparam logic       DEST_ACC    = 1'h0;
    localparam logic       DEST_FILE   = 1'h1;

    localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;
    localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;

    // ========================================
    // Execution phases
    typedef enum logic [1:0] {
        SJI_EXEC,
        SJI_FLUSH
    } sji_phase_t;

endpackage : sji_pkg

// ---- shared/sji_res_if.sv ----
interface sji_res_if;
    import sji_pkg::*;
    logic              valid;
    logic              is_dec;
    logic              is_inc;
    logic              is_jump;
    logic              dest;
    logic [FADDR_W-1:0] faddr;
    logic [LIT_W-1:0]  lit;
    logic [DATA_W-1:0] result;
    logic              zero;

    modport dec (output valid, is_dec, is_inc, is_jump, dest, faddr, lit, result, zero);
    modport core (input valid, is_dec, is_inc, is_jump, dest, faddr, lit, result, zero);
endinterface : sji_res_if

// ---- verilog/sji_decode.sv ----
module sji_decode
    import sji_pkg::*;
(
    input  wire logic [INSN_W-1:0] insn_in,
    input  wire logic              insn_valid_in,
    input  wire logic [DATA_W-1:0] file_rdata_in,
    sji_res_if.dec                 res
);
    // ========================================
    // Opcode match and arithmetic
    always_comb begin
        res.valid   = insn_valid_in;
        res.is_dec  = insn_in[OP6_HI:OP6_LO] == OP_DEC_SKIP;
        res.is_inc  = insn_in[OP6_HI:OP6_LO] == OP_INC;
        res.is_jump = insn_in[OP3_HI:OP3_LO] == OP_JUMP;
        res.dest    = insn_in[DEST_BIT];
        res.faddr   = insn_in[FADDR_HI:0];
        res.lit     = insn_in[LIT_HI:0];
        if (res.is_dec) begin
            res.result = file_rdata_in - DATA_ONE;
        end else begin
            res.result = file_rdata_in + DATA_ONE;
        end
        res.zero = res.result == DATA_ZERO;
    end
endmodule : sji_decode

// ---- verilog/sji_exec.sv ----
module sji_exec
    import sji_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic [INSN_W-1:0]  insn_in,
    input  wire logic               insn_valid_in,
    input  wire logic [DATA_W-1:0]  file_rdata_in,
    input  wire logic [LATCH_W-1:0] pc_high_latch_in,
    output logic [PC_W-1:0]         pc_out,
    output logic [FADDR_W-1:0]      file_addr_out,
    output logic [DATA_W-1:0]       file_wdata_out,
    output logic                    file_we_out,
    output logic [DATA_W-1:0]       acc_out,
    output logic                    zero_flag_out,
    output logic                    zero_we_out,
    output logic                    flush_out
);
    // ========================================
    // State
    typedef struct packed {
        sji_phase_t         phase;
        logic [PC_W-1:0]    pc;
        logic [FADDR_W-1:0] faddr;
        logic [DATA_W-1:0]  wdata;
        logic               we;
        logic [DATA_W-1:0]  acc;
        logic               zero;
        logic               zero_we;
        logic               flush;
    } sji_state_t;

    // Every field returns here while reset is held
    localparam sji_state_t ST_RESET = '{
        phase:   SJI_EXEC,
        pc:      PC_RESET,
        faddr:   '0,
        wdata:   DATA_ZERO,
        we:      1'b0,
        acc:     DATA_ZERO,
        zero:    1'b0,
        zero_we: 1'b0,
        flush:   1'b0
    };

    // ========================================
    // Operation classes
    // Words outside the three instructions fall into the none class
    typedef enum logic [1:0] {
        OPK_NONE,
        OPK_DEC,
        OPK_INC,
        OPK_JUMP
    } sji_opk_t;

    sji_state_t         st_q;
    sji_state_t         st_d;

    sji_opk_t           opk;
    logic [FADDR_W-1:0] rd_addr;
    logic [PC_W-1:0]    seq_pc;
    logic [PC_W-1:0]    jump_pc;

    sji_res_if res ();

    sji_decode u_dec (
        .insn_in       (insn_in),
        .insn_valid_in (insn_valid_in),
        .file_rdata_in (file_rdata_in),
        .res           (res)
    );

    // ========================================
    // Timing seen from the far side
    // Results leave one cycle after the word is taken. A file write is still
    // pending when the next word reads its operand, so the register file must
    // forward a pending write to a read of the same cell; there is no interlock.
    // pc_out is the next fetch address. After a jump the target word is
    // fetched during the dead cycle, so the counter then runs one past it.
    // A stall holds every register but the pulses and the file address, the flush phase included.

    // ========================================
    // Operand, fetch address and jump target
    // File read address comes straight from the word so the operand is
    // available in the same cycle; the write port uses the registered copy.
    assign rd_addr = res.faddr;

    // The sequential fetch address wraps silently at the top of program space
    assign seq_pc = st_q.pc + PC_ONE;

    // Only two latch bits reach the counter; the rest of the latch is ignored
    assign jump_pc = {pc_high_latch_in[LATCH_HI:LATCH_LO], res.lit};

    // At most one class matches, so the order of the tests is immaterial
    assign opk = res.is_dec  ? OPK_DEC  :
                 res.is_inc  ? OPK_INC  :
                 res.is_jump ? OPK_JUMP : OPK_NONE;

    // ========================================
    // Next state
    always_comb begin
        // Pulses default low so each stands for exactly one cycle
        st_d         = st_q;
        st_d.we      = 1'b0;
        st_d.zero_we = 1'b0;
        st_d.flush   = 1'b0;
        st_d.faddr   = rd_addr;

        case (st_q.phase)
            SJI_EXEC: begin
                // A stalled cycle leaves every register but the pulses and faddr, which follows the word
                if (res.valid) begin
                    st_d.pc = seq_pc;

                    case (opk)
                        OPK_DEC: begin
                            case (res.dest)
                                DEST_FILE: begin
                                    st_d.we    = 1'b1;
                                    st_d.wdata = res.result;
                                end
                                DEST_ACC: begin
                                    st_d.acc   = res.result;
                                end
                                default: begin
                                    // An unknown destination bit writes nowhere
                                end
                            endcase
                            // Status is left alone, so a skip never disturbs the zero flag
                            if (res.zero) begin
                                st_d.phase = SJI_FLUSH;
                                st_d.flush = 1'b1;
                            end
                        end

                        OPK_INC: begin
                            case (res.dest)
                                DEST_FILE: begin
                                    st_d.we    = 1'b1;
                                    st_d.wdata = res.result;
                                end
                                DEST_ACC: begin
                                    st_d.acc   = res.result;
                                end
                                default: begin
                                    // An unknown destination bit writes nowhere
                                end
                            endcase
                            st_d.zero    = res.zero;
                            st_d.zero_we = 1'b1;
                        end

                        OPK_JUMP: begin
                            // Counter bits 12..11 come from the latch, the rest from the literal
                            st_d.pc    = jump_pc;
                            st_d.phase = SJI_FLUSH;
                            st_d.flush = 1'b1;
                        end

                        default: begin
                            // Words outside the three classes only advance the counter
                            st_d.pc = seq_pc;
                        end
                    endcase
                end
            end

            SJI_FLUSH: begin
                // Prefetched word is dropped; only the fetch address advances.
                // The phase holds through a stall so a late word is still dropped.
                if (res.valid) begin
                    st_d.pc    = seq_pc;
                    st_d.phase = SJI_EXEC;
                end
            end

            default: begin
                st_d.phase = SJI_EXEC;
            end
        endcase
    end

    // ========================================
    // State register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================
    // Fetch side
    // The flush pulse stands for one cycle; the counter holds through stalls
    assign pc_out         = st_q.pc;
    assign flush_out      = st_q.flush;

    // ========================================
    // Register file side
    // Data stays put after the write pulse has gone; the address follows each new word
    assign file_addr_out  = st_q.faddr;
    assign file_wdata_out = st_q.wdata;
    assign file_we_out    = st_q.we;

    // ========================================
    // Core side
    // The zero flag only moves on an increment; decrement never pulses it
    assign acc_out        = st_q.acc;
    assign zero_flag_out  = st_q.zero;
    assign zero_we_out    = st_q.zero_we;

endmodule : sji_exec

// ---- tb/sji_checker.sv ----
module sji_checker
    import sji_pkg::*;
(
    input wire logic [0:0]         clk_in,
    input wire logic               rst_in,
    input wire logic [INSN_W-1:0]  insn_in,
    input wire logic               insn_valid_in,
    input wire logic [DATA_W-1:0]  file_rdata_in,
    input wire logic [LATCH_W-1:0] pc_high_latch_in,
    input wire logic [PC_W-1:0]    pc_out,
    input wire logic [FADDR_W-1:0] file_addr_out,
    input wire logic [DATA_W-1:0]  file_wdata_out,
    input wire logic               file_we_out,
    input wire logic [DATA_W-1:0]  acc_out,
    input wire logic               zero_flag_out,
    input wire logic               zero_we_out,
    input wire logic               flush_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ========
    // Decode
    logic ok, dec, inc, jmp, void_q;
    logic [PC_W-1:0] tgt;
    // The dropped word may come after a stall, so the flush phase is tracked
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            void_q <= 1'b0;
        end else begin
            void_q <= (flush_out | void_q) & ~insn_valid_in;
        end
    end
    assign ok  = insn_valid_in & ~flush_out & ~void_q;
    assign dec = ok & (insn_in[OP6_HI:OP6_LO] == OP_DEC_SKIP);
    assign inc = ok & (insn_in[OP6_HI:OP6_LO] == OP_INC);
    assign jmp = ok & (insn_in[OP3_HI:OP3_LO] == OP_JUMP);
    assign tgt = {pc_high_latch_in[LATCH_HI:LATCH_LO], insn_in[LIT_HI:0]};
    AST_DEC_F: assert property (dec & insn_in[DEST_BIT] |=> file_we_out &&
        file_wdata_out == $past(file_rdata_in) - DATA_ONE) else $error("dec file write");
    AST_DEC_W: assert property (dec & !insn_in[DEST_BIT] |=> !file_we_out &&
        acc_out == $past(file_rdata_in) - DATA_ONE) else $error("dec acc write");
    AST_DEC_Z: assert property (dec |=> !zero_we_out && $stable(zero_flag_out))
        else $error("dec touched zero");
    AST_SKIP: assert property (dec |=> flush_out == ($past(file_rdata_in) == DATA_ONE))
        else $error("skip wrong");
    AST_JMP: assert property (jmp |=> flush_out && pc_out == $past(tgt))
        else $error("jump target");
    AST_JMP2: assert property (jmp ##1 insn_valid_in |=> pc_out == $past(pc_out) + PC_ONE)
        else $error("jump dead cycle");
    AST_INC: assert property (inc |=> zero_we_out &&
        zero_flag_out == ($past(file_rdata_in) == 8'hFF)) else $error("inc zero");
    AST_INC_F: assert property (inc & insn_in[DEST_BIT] |=> file_we_out &&
        file_wdata_out == $past(file_rdata_in) + DATA_ONE) else $error("inc write");
    AST_PC: assert property (ok & !jmp |=> pc_out == $past(pc_out) + PC_ONE)
        else $error("pc step");
    cover property (dec ##1 flush_out);
    cover property (jmp);
    AST_VOID: assert property (insn_valid_in & (flush_out | void_q) |=>
        pc_out == $past(pc_out) + PC_ONE && !file_we_out && !zero_we_out && !flush_out)
        else $error("dropped word acted");
    cover property (inc & file_rdata_in == 8'hFF);
    cover property (flush_out & !insn_valid_in ##1 insn_valid_in);
endmodule : sji_checker

bind sji_exec sji_checker u_chk (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .insn_in          (insn_in),
    .insn_valid_in    (insn_valid_in),
    .file_rdata_in    (file_rdata_in),
    .pc_high_latch_in (pc_high_latch_in),
    .pc_out           (pc_out),
    .file_addr_out    (file_addr_out),
    .file_wdata_out   (file_wdata_out),
    .file_we_out      (file_we_out),
    .acc_out          (acc_out),
    .zero_flag_out    (zero_flag_out),
    .zero_we_out      (zero_we_out),
    .flush_out        (flush_out)
);

// ---- tb/sji_regfile.sv ----
module sji_regfile
    import sji_pkg::*;
(
    input wire logic               clk_in,
    input wire logic [INSN_W-1:0]  insn_in,
    input wire logic [FADDR_W-1:0] file_addr_out,
    input wire logic [DATA_W-1:0]  file_wdata_out,
    input wire logic               file_we_out,
    output logic [DATA_W-1:0]      file_rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========
    // Storage, odd cells near wrap
    logic [DATA_W-1:0] mem [128];
    logic [FADDR_W-1:0] ra;
    initial for (int i = 0; i < 128; i++) mem[i] = i[0] ? 8'hFF : 8'h01;
    always @(posedge clk_in) if (file_we_out) mem[file_addr_out] <= file_wdata_out;
    assign ra = insn_in[FADDR_HI:0];
    // Bypass, so back-to-back reads see the pending write
    assign file_rdata_in = (file_we_out && file_addr_out == ra) ? file_wdata_out : mem[ra];
endmodule : sji_regfile

// ---- tb/tb.sv ----
module tb;
    import sji_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ========
    // Signals and model
    logic clk_in = 0, rst_in = 1, insn_valid_in = 0, file_we_out, zero_flag_out;
    logic zero_we_out, flush_out, m_z = 0, m_fl = 0, e_we, e_zw, v;
    logic [INSN_W-1:0] insn_in = '0, w;
    logic [LATCH_W-1:0] pc_high_latch_in = '0;
    logic [DATA_W-1:0] file_rdata_in, file_wdata_out, acc_out, m_acc = 0, r, res;
    logic [DATA_W-1:0] m_reg [128];
    logic [PC_W-1:0] pc_out, m_pc = 0;
    logic [FADDR_W-1:0] file_addr_out, a;
    logic [31:0] rs = 55;
    int fail_count, num_checks;
    always #5 clk_in = ~clk_in;
    sji_exec dut (
        .clk_in           (clk_in),
        .rst_in           (rst_in),
        .insn_in          (insn_in),
        .insn_valid_in    (insn_valid_in),
        .file_rdata_in    (file_rdata_in),
        .pc_high_latch_in (pc_high_latch_in),
        .pc_out           (pc_out),
        .file_addr_out    (file_addr_out),
        .file_wdata_out   (file_wdata_out),
        .file_we_out      (file_we_out),
        .acc_out          (acc_out),
        .zero_flag_out    (zero_flag_out),
        .zero_we_out      (zero_we_out),
        .flush_out        (flush_out)
    );
    sji_regfile u_rf (
        .clk_in         (clk_in),
        .insn_in        (insn_in),
        .file_addr_out  (file_addr_out),
        .file_wdata_out (file_wdata_out),
        .file_we_out    (file_we_out),
        .file_rdata_in  (file_rdata_in)
    );
    task chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, s, e);
        end
    endtask : chk
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction : xorshift
    task summarize;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // ========
    // Random stream, model updated at each consuming edge
    initial begin
        for (int i = 0; i < 128; i++) m_reg[i] = i[0] ? 8'hFF : 8'h01;
        repeat (3) @(posedge clk_in);
        rst_in <= 0;
        for (int n = 0; n < 800; n++) begin
            @(posedge clk_in);
            {e_we, e_zw, v, w, a} = {2'b0, insn_valid_in, insn_in, insn_in[6:0]};
            r = m_reg[a];
            if (v) m_pc++;
            if (v && m_fl) m_fl = 0;
            else if (v && w[13:9] == 5'h05) begin
                res = (w[13:8] == OP_DEC_SKIP) ? r - DATA_ONE : r + DATA_ONE;
                if (w[DEST_BIT]) {m_reg[a], e_we} = {res, 1'b1};
                else m_acc = res;
                if (w[13:8] == OP_INC) {m_z, e_zw} = {res == 0, 1'b1};
                else m_fl = (res == 0);
            end else if (v && w[13:11] == OP_JUMP) begin
                m_pc = {pc_high_latch_in[4:3], w[10:0]};
                m_fl = 1;
            end
            rs = xorshift(rs);
            insn_valid_in <= rs[0] | rs[1];
            pc_high_latch_in <= rs[31:24];
            case (rs[3:2])
                0: insn_in <= {OP_DEC_SKIP, rs[7], 4'h0, rs[6:4]};
                1: insn_in <= {OP_INC, rs[7], 4'h0, rs[6:4]};
                2: insn_in <= {OP_JUMP, rs[26:16]};
                default: insn_in <= {2'b11, rs[19:8]};
            endcase
            #1;
            chk(pc_out, m_pc);
            chk(acc_out, m_acc);
            chk(zero_flag_out, m_z);
            if (v) chk({flush_out, file_we_out, zero_we_out}, {m_fl, e_we, e_zw});
            else chk({flush_out, file_we_out, zero_we_out}, 16'h0000);
            if (e_we) chk({file_addr_out, file_wdata_out}, {a, res});
        end
        summarize();
    end
endmodule : tb
